// ===== verification/pci_term_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "pci_term_defines.svh"
module pci_term_asserts #(
	parameter logic [31:0] OPREG_BASE = 32'h00001000,
	parameter logic [31:0] OPREG_MASK = 32'hFFFFFFC0
) (
	input wire logic CLK_SYS_I,
	input wire logic RST_B_I,
	input wire logic frame_n,
	input wire logic irdy_n,
	input wire logic [3:0] cbe_n,
	input wire logic [31:0] ad,
	input wire logic ad_mst_oe,
	input wire logic ad_tgt_oe,
	input wire logic trdy_n,
	input wire logic stop_n,
	input wire logic devsel_n
);
	// command lanes are active low on the wire
	wire [3:0] cmd = ~cbe_n;
	wire mem_cmd = (cmd == `CMD_MEM_RD) || (cmd == `CMD_MEM_WR);
	wire op_hit = mem_cmd && ((ad & OPREG_MASK) == OPREG_BASE);
	wire claimable = cmd inside {`CMD_IO_RD, `CMD_IO_WR, `CMD_MEM_RD, `CMD_MEM_WR,
		`CMD_CFG_RD, `CMD_CFG_WR, `CMD_MEM_RDM, `CMD_MEM_RDL, `CMD_MEM_WRI};
	logic frame_reg;
	logic rd_reg;
	// remember the direction of the running transaction, since ad_mst_oe may drop in waits
	always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			frame_reg <= 1'b1;
			rd_reg <= 1'b0;
		end else begin
			frame_reg <= frame_n;
			if (frame_reg && !frame_n) begin
				rd_reg <= cbe_n[0];
			end
		end
	end
	default clocking cb @(posedge CLK_SYS_I);
	endclocking
	default disable iff (!RST_B_I);
	// address phases of the kinds that carry fixed answers
	sequence s_addr_rd;
		$fell(frame_n) && cbe_n[0];
	endsequence
	sequence s_op_rd;
		$fell(frame_n) && op_hit && cbe_n[0];
	endsequence
	sequence s_op_wr;
		$fell(frame_n) && op_hit && !cbe_n[0];
	endsequence
	a_no_tgt_abort: assert property (!stop_n |-> !devsel_n)
		else $error("stop seen without device select");
	a_read_turn: assert property (s_addr_rd |=> !ad_mst_oe && !ad_tgt_oe && trdy_n)
		else $error("read lacks a turnaround clock");
	a_write_direct: assert property ($fell(frame_n) && !cbe_n[0] |=> ad_mst_oe && !ad_tgt_oe)
		else $error("write data does not follow the address");
	a_read_data: assert property (!trdy_n && rd_reg |-> ad_tgt_oe)
		else $error("read ready without driven data");
	a_op_single_rd: assert property (s_op_rd ##1 frame_n |=> stop_n)
		else $error("stop on a single register read");
	a_op_burst_rd: assert property (s_op_rd ##1 (!frame_n && !irdy_n) |=> !stop_n && !trdy_n)
		else $error("register burst read not disconnected");
	a_op_wr_stop: assert property (s_op_wr ##1 !frame_n |=> !stop_n)
		else $error("register burst write without stop in clock three");
	a_frame_drop: assert property (!stop_n && !frame_n |=> frame_n)
		else $error("frame kept after stop");
	a_stop_holds: assert property (!stop_n && !frame_n |=> !stop_n && !devsel_n)
		else $error("stop released before frame");
	a_no_claim: assert property ($fell(frame_n) && !claimable |=> devsel_n [*4])
		else $error("device select on an unsupported command");
endmodule : pci_term_asserts
`default_nettype wire

// ===== verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_sys, rst_b, req, lock, rd_valid, rd_pend, wr_full, rom_ready;
	logic [3:0] cmd, len, c;
	logic [31:0] addr, wdata, rd_data, lat;
	logic [7:0] modes;
	logic busy, done, lock_own, xfer_wr, locked;
	logic [3:0] phase;
	logic [31:0] rdata, t_addr, xfer_addr, wr_data;
	pci_term_pkg::result_type result;
	pci_term_pkg::region_type region;
	logic data_ack, xfer_o;
	logic [3:0] wr_be;
	int acks = 0;
	int xfers = 0;
	int base_a, base_x;
	localparam logic [47:0] CODES = 48'hCEFAB014589D;
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;
	int i;
	pci_term_if link ();
	pci_term_initiator u_pci_term_initiator (.CLK_SYS_I(clk_sys), .RST_B_I(rst_b), .LINK(link),
		.REQ_I(req), .CMD_I(cmd), .ADDR_I(addr), .WDATA_I(wdata), .BE_I(4'hF), .LEN_I(len),
		.LOCK_I(lock), .BUSY_O(busy), .DONE_O(done), .RESULT_O(result), .DATA_ACK_O(data_ack),
		.PHASE_O(phase), .RDATA_O(rdata), .LOCK_OWN_O(lock_own));
	pci_term_target u_pci_term_target (.CLK_SYS_I(clk_sys), .RST_B_I(rst_b), .LINK(link),
		.IDSEL_I(1'b1), .SPECIAL_MODES_I(modes), .RD_DATA_I(rd_data), .RD_VALID_I(rd_valid),
		.RD_PEND_I(rd_pend), .WR_FULL_I(wr_full), .ROM_READY_I(rom_ready), .ADDR_O(t_addr),
		.REGION_O(region), .XFER_O(xfer_o), .XFER_WR_O(xfer_wr), .XFER_ADDR_O(xfer_addr),
		.WR_DATA_O(wr_data), .WR_BE_O(wr_be), .LOCKED_O(locked));
	pci_term_asserts u_pci_term_asserts (.CLK_SYS_I(clk_sys), .RST_B_I(rst_b),
		.frame_n(link.frame_n), .irdy_n(link.irdy_n), .cbe_n(link.cbe_n), .ad(link.ad),
		.ad_mst_oe(link.ad_mst_oe), .ad_tgt_oe(link.ad_tgt_oe), .trdy_n(link.trdy_n),
		.stop_n(link.stop_n), .devsel_n(link.devsel_n));
	// local read word is a known pattern of the phase address
	function automatic logic [31:0] pat(input logic [31:0] a);
		return a ^ 32'h5A5A0000;
	endfunction : pat
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : final_report
	task automatic bad(input string s);
		num_errors++;
		$display("ERROR at %0t: %s", $time, s);
	endtask : bad
	task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) bad($sformatf("word %h expected %h", got, exp));
	endtask : chk_w
	task automatic chk_r(input pci_term_pkg::result_type got, input pci_term_pkg::result_type exp);
		check_count++;
		if (got !== exp) bad($sformatf("result %0d expected %0d", got, exp));
	endtask : chk_r
	// one whole transaction; returns once the done pulse is seen
	task automatic xact(input logic [3:0] cm, input logic [31:0] a, input logic [3:0] n,
		input logic lk);
		int k;
		k = 0;
		repeat (2) @(posedge clk_sys);
		#1;
		while (busy !== 1'b0 && k < 200) begin
			@(posedge clk_sys);
			#1;
			k++;
		end
		@(posedge clk_sys);
		cmd <= cm;
		addr <= a;
		len <= n;
		lock <= lk;
		req <= 1'b1;
		@(posedge clk_sys);
		req <= 1'b0;
		k = 0;
		do begin
			@(posedge clk_sys);
			#1;
			k++;
		end while (done !== 1'b1 && k < 200);
		lat = 32'(k);
		if (k >= 200) begin
			bad("no completion");
			final_report();
		end
	endtask : xact
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// local word follows the current phase address at once; the target takes it at its offer
	assign rd_data = pat(t_addr);
	// count per-transfer pulses on both ends; each pulse is one word moved
	always @(posedge clk_sys) begin
		if (data_ack === 1'b1)
			acks++;
		if (xfer_o === 1'b1)
			xfers++;
	end
	// cut a hang short well past the expected run length
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 6000) begin
			bad("run too long");
			final_report();
		end
	end
	initial begin
		rst_b = 1'b0; req = 1'b0; cmd = 4'h0; addr = 32'h0; wdata = 32'h0; len = 4'h1;
		lock = 1'b0; modes = 8'h01; rd_valid = 1'b0; rd_pend = 1'b0;
		wr_full = 1'b0; rom_ready = 1'b0;
		repeat (20) @(posedge clk_sys);
		rst_b <= 1'b1;
		xact(4'h6, 32'h00001004, 4'h1, 1'b0);
		chk_r(result, pci_term_pkg::RES_OK);
		chk_w(rdata, pat(32'h00001004));
		xact(4'h6, 32'h00001008, 4'h2, 1'b0);
		chk_r(result, pci_term_pkg::RES_DISC);
		chk_w({28'h0000000, phase}, 32'h1);
		wdata <= 32'hC0DE1234;
		xact(4'h7, 32'h00001010, 4'h2, 1'b0);
		chk_r(result, pci_term_pkg::RES_DISC);
		chk_w(wr_data, 32'hC0DE1234);
		chk_w({31'h0, xfer_wr}, 32'h1);
		chk_w({28'h0000000, wr_be}, 32'h0000000F);
		$display("test register access finished");
		base_a = acks;
		base_x = xfers;
		xact(4'h7, 32'h00010000, 4'h4, 1'b0);
		chk_r(result, pci_term_pkg::RES_OK);
		chk_w(xfer_addr, 32'h0001000C);
		wr_full <= 1'b1;
		xact(4'h7, 32'h00010000, 4'h2, 1'b0);
		chk_r(result, pci_term_pkg::RES_RETRY);
		chk_w({28'h0000000, phase}, 32'h0);
		chk_w(32'(acks - base_a), 32'h4);
		chk_w(32'(xfers - base_x), 32'h4);
		wr_full <= 1'b0;
		xact(4'h6, 32'h00010000, 4'h1, 1'b0);
		chk_r(result, pci_term_pkg::RES_RETRY);
		$display("test fifo states finished");
		rd_pend <= 1'b1;
		xact(4'h6, 32'h00010000, 4'h1, 1'b0);
		chk_r(result, pci_term_pkg::RES_RETRY);
		chk_w({31'h0, (lat >= 32'h10) && (lat <= 32'h18)}, 32'h1);
		modes <= 8'h00;
		fork
			xact(4'h6, 32'h00010000, 4'h1, 1'b0);
			begin
				repeat (40) @(posedge clk_sys);
				rd_valid <= 1'b1;
			end
		join
		chk_r(result, pci_term_pkg::RES_OK);
		chk_w(rdata, pat(32'h00010000));
		rd_pend <= 1'b0;
		modes <= 8'h01;
		$display("test latency limit finished");
		xact(4'h6, 32'h00010001, 4'h2, 1'b0);
		chk_r(result, pci_term_pkg::RES_DISC);
		xact(4'h6, 32'h00010000, 4'h3, 1'b0);
		chk_w({28'h0000000, phase}, 32'h3);
		// second phase starves with a fetch pending: the later-phase limit must cut it
		rd_pend <= 1'b1;
		fork
			xact(4'h6, 32'h00010000, 4'h2, 1'b0);
			begin
				wait (busy === 1'b1);
				wait (xfer_o === 1'b1);
				@(posedge clk_sys);
				rd_valid <= 1'b0;
			end
		join
		chk_r(result, pci_term_pkg::RES_DISC);
		chk_w({31'h0, (lat >= 32'hC) && (lat <= 32'h10)}, 32'h1);
		rd_pend <= 1'b0;
		rd_valid <= 1'b1;
		xact(4'h6, 32'h000C0000, 4'h1, 1'b0);
		chk_r(result, pci_term_pkg::RES_RETRY);
		rom_ready <= 1'b1;
		xact(4'h6, 32'h000C0004, 4'h1, 1'b0);
		chk_w(rdata, pat(32'h000C0004));
		chk_w({30'h0, region}, {30'h0, pci_term_pkg::RG_ROM});
		xact(4'h6, 32'h000C0008, 4'h2, 1'b0);
		chk_r(result, pci_term_pkg::RES_DISC);
		$display("test burst order and rom finished");
		// twelve command codes, all but 2, 3, 6 and 7, claimed or refused
		for (i = 11; i >= 0; i--) begin
			c = CODES[i * 4 +: 4];
			xact(c, (c[3:1] == 3'h5) ? 32'h0 : (c == 4'hF) ? 32'h00010000 : 32'h00001000,
				4'h1, 1'b0);
			chk_r(result, (c inside {4'hA, 4'hB, 4'hC, 4'hE, 4'hF}) ? pci_term_pkg::RES_OK :
				pci_term_pkg::RES_MABORT);
		end
		$display("test command codes finished");
		xact(4'h7, 32'h00010000, 4'h1, 1'b1);
		chk_w({30'h0, lock_own, locked}, 32'h3);
		xact(4'h7, 32'h00010004, 4'h1, 1'b0);
		repeat (2) @(posedge clk_sys);
		#1;
		chk_w({31'h0, locked}, 32'h0);
		$display("test lock finished");
		final_report();
	end
endmodule : tb
`default_nettype wire

// ===== verilog/pci_term_defines.svh
`ifndef PCI_TERM_DEFINES_SVH
`define PCI_TERM_DEFINES_SVH
// bus command codes, active-high form of the command lanes
`define CMD_IO_RD 4'h2
`define CMD_IO_WR 4'h3
`define CMD_MEM_RD 4'h6
`define CMD_MEM_WR 4'h7
`define CMD_CFG_RD 4'hA
`define CMD_CFG_WR 4'hB
`define CMD_MEM_RDM 4'hC
`define CMD_MEM_RDL 4'hE
`define CMD_MEM_WRI 4'hF
// low address bits at the address phase
`define BURST_LINEAR 2'h0
`define CFG_TYPE0 2'h0
// target latency limits in bus clocks
`define LAT_FIRST_CLKS 5'h10
`define LAT_LATER_CLKS 5'h08
`define LAT_CNT_MAX 5'h1F
// bit of the special-modes byte that keeps latency enforcement on
`define LAT_EN_BIT 0
// master abort if no device select after this many data clocks
`define DEVSEL_TIMEOUT 3'h5
`define ADDR_STEP 32'h00000004
`endif

// ===== verilog/pci_term_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pci_term_if;
	logic frame_n;
	logic irdy_n;
	logic lock_n;
	logic [3:0] cbe_n;
	logic [31:0] ad_mst;
	logic ad_mst_oe;
	logic trdy_n;
	logic stop_n;
	logic devsel_n;
	logic [31:0] ad_tgt;
	logic ad_tgt_oe;
	wire [31:0] ad;
	// shared address/data wire: target wins when it enables, master otherwise
	assign ad = ad_tgt_oe ? ad_tgt : ad_mst;
	modport target(input frame_n, irdy_n, lock_n, cbe_n, ad,
		output trdy_n, stop_n, devsel_n, ad_tgt, ad_tgt_oe);
	modport initiator(input trdy_n, stop_n, devsel_n, ad,
		output frame_n, irdy_n, lock_n, cbe_n, ad_mst, ad_mst_oe);
endinterface : pci_term_if
`default_nettype wire

// ===== verilog/pci_term_initiator.sv
`timescale 1ns/1ps
`default_nettype none
`include "pci_term_defines.svh"
module pci_term_initiator #(
	parameter logic [2:0] DEVSEL_WAIT = `DEVSEL_TIMEOUT
) (
	input wire logic CLK_SYS_I,
	input wire logic RST_B_I,
	pci_term_if.initiator LINK,
	input wire logic REQ_I,
	input wire logic [3:0] CMD_I,
	input wire logic [31:0] ADDR_I,
	input wire logic [31:0] WDATA_I,
	input wire logic [3:0] BE_I,
	input wire logic [3:0] LEN_I,
	input wire logic LOCK_I,
	output logic BUSY_O,
	output logic DONE_O,
	output pci_term_pkg::result_type RESULT_O,
	output logic DATA_ACK_O,
	output logic [3:0] PHASE_O,
	output logic [31:0] RDATA_O,
	output logic LOCK_OWN_O
);
	pci_term_pkg::mst_state_type state_reg, state_next;
	pci_term_pkg::result_type res_reg, res_next;
	logic frame_n_reg, frame_n_next, irdy_n_reg, irdy_n_next, lock_n_reg, lock_n_next;
	logic oe_reg, oe_next, wr_reg, done_reg, done_next, own_reg, own_next, got_reg;
	logic [3:0] cbe_n_reg, cbe_n_next, left_reg, left_next, phase_reg;
	logic [31:0] ad_reg, ad_next, rdata_reg;
	logic [2:0] wait_reg;
	logic busy_reg;

	// phase completion seen from the target's registered strobes
	wire logic xfer = (state_reg == pci_term_pkg::M_DATA) & ~irdy_n_reg & ~LINK.trdy_n;
	wire logic ph_end = (state_reg == pci_term_pkg::M_DATA) & ~irdy_n_reg & (~LINK.trdy_n | ~LINK.stop_n);
	wire logic abort = LINK.devsel_n & (wait_reg >= DEVSEL_WAIT);

	// one wait state after each transfer but the last lets the user present the next word on PHASE_O
	always_comb begin
		state_next = state_reg;
		frame_n_next = frame_n_reg;
		irdy_n_next = irdy_n_reg;
		lock_n_next = lock_n_reg;
		cbe_n_next = cbe_n_reg;
		ad_next = ad_reg;
		oe_next = oe_reg;
		left_next = left_reg;
		own_next = own_reg;
		done_next = 1'b0;
		res_next = res_reg;
		case (state_reg)
			pci_term_pkg::M_IDLE: if (REQ_I) begin
				frame_n_next = 1'b0;
				lock_n_next = 1'b1;
				cbe_n_next = ~CMD_I;
				ad_next = ADDR_I;
				oe_next = 1'b1;
				left_next = LEN_I;
				state_next = pci_term_pkg::M_ADDR;
			end
			pci_term_pkg::M_ADDR: begin
				irdy_n_next = 1'b0;
				frame_n_next = (left_reg <= 4'h1);
				lock_n_next = ~LOCK_I;
				own_next = LOCK_I;
				cbe_n_next = ~BE_I;
				ad_next = WDATA_I;
				oe_next = wr_reg;
				state_next = pci_term_pkg::M_DATA;
			end
			pci_term_pkg::M_DATA: begin
				if (abort | (ph_end & frame_n_reg)) begin
					frame_n_next = 1'b1;
					irdy_n_next = 1'b1;
					oe_next = 1'b0;
					done_next = 1'b1;
					if (abort)
						res_next = pci_term_pkg::RES_MABORT;
					else if (LINK.stop_n)
						res_next = pci_term_pkg::RES_OK;
					else if (xfer | got_reg)
						res_next = pci_term_pkg::RES_DISC;
					else
						res_next = pci_term_pkg::RES_RETRY;
					state_next = pci_term_pkg::M_IDLE;
				end else if (~LINK.stop_n) begin
					frame_n_next = 1'b1;
				end else if (xfer) begin
					irdy_n_next = 1'b1;
					left_next = left_reg - 4'h1;
					state_next = pci_term_pkg::M_WAIT;
				end
			end
			pci_term_pkg::M_WAIT: begin
				irdy_n_next = 1'b0;
				frame_n_next = (left_reg <= 4'h1);
				ad_next = WDATA_I;
				cbe_n_next = ~BE_I;
				state_next = pci_term_pkg::M_DATA;
			end
			default: state_next = pci_term_pkg::M_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			state_reg <= pci_term_pkg::M_IDLE;
			frame_n_reg <= 1'b1;
			irdy_n_reg <= 1'b1;
			lock_n_reg <= 1'b1;
			cbe_n_reg <= 4'hF;
			ad_reg <= 32'h00000000;
			oe_reg <= 1'b0;
			left_reg <= 4'h0;
			own_reg <= 1'b0;
			done_reg <= 1'b0;
			res_reg <= pci_term_pkg::RES_OK;
			busy_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			frame_n_reg <= frame_n_next;
			irdy_n_reg <= irdy_n_next;
			lock_n_reg <= lock_n_next;
			cbe_n_reg <= cbe_n_next;
			ad_reg <= ad_next;
			oe_reg <= oe_next;
			left_reg <= left_next;
			own_reg <= own_next;
			done_reg <= done_next;
			res_reg <= res_next;
			busy_reg <= (state_next != pci_term_pkg::M_IDLE);
		end
	end

	// per-transaction bookkeeping and user-side data
	always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			wr_reg <= 1'b0;
			got_reg <= 1'b0;
			wait_reg <= 3'h0;
			phase_reg <= 4'h0;
			rdata_reg <= 32'h00000000;
			DATA_ACK_O <= 1'b0;
		end else begin
			DATA_ACK_O <= xfer;
			if (state_reg == pci_term_pkg::M_IDLE) begin
				wr_reg <= CMD_I[0];
				got_reg <= 1'b0;
				phase_reg <= 4'h0;
			end else if (xfer) begin
				got_reg <= 1'b1;
				phase_reg <= phase_reg + 4'h1;
			end
			if (xfer & ~wr_reg)
				rdata_reg <= LINK.ad;
			if (state_reg != pci_term_pkg::M_DATA)
				wait_reg <= 3'h0;
			else if (LINK.devsel_n & (wait_reg != 3'h7))
				wait_reg <= wait_reg + 3'h1;
		end
	end

	assign LINK.frame_n = frame_n_reg;
	assign LINK.irdy_n = irdy_n_reg;
	assign LINK.lock_n = lock_n_reg;
	assign LINK.cbe_n = cbe_n_reg;
	assign LINK.ad_mst = ad_reg;
	assign LINK.ad_mst_oe = oe_reg;
	assign BUSY_O = busy_reg; // registered copy of the state test, so the port leaves a flop
	assign DONE_O = done_reg;
	assign RESULT_O = res_reg;
	assign PHASE_O = phase_reg;
	assign RDATA_O = rdata_reg;
	assign LOCK_OWN_O = own_reg;
endmodule : pci_term_initiator
`default_nettype wire

// ===== verilog/pci_term_pkg.sv
`default_nettype none
package pci_term_pkg;
	typedef enum logic [4:0] {
		T_IDLE = 5'h01,
		T_TURN = 5'h02,
		T_DATA = 5'h04,
		T_GAP = 5'h08,
		T_BACKOFF = 5'h10
	} tgt_state_type;
	typedef enum logic [3:0] {
		M_IDLE = 4'h1,
		M_ADDR = 4'h2,
		M_DATA = 4'h4,
		M_WAIT = 4'h8
	} mst_state_type;
	typedef enum logic [1:0] {
		RG_CFG = 2'h0,
		RG_OPREG = 2'h1,
		RG_ROM = 2'h2,
		RG_PASS = 2'h3
	} region_type;
	typedef enum logic [1:0] {
		RES_OK = 2'h0,
		RES_DISC = 2'h1,
		RES_RETRY = 2'h2,
		RES_MABORT = 2'h3
	} result_type;
endpackage : pci_term_pkg
`default_nettype wire

// ===== verilog/pci_term_target.sv
`timescale 1ns/1ps
`default_nettype none
`include "pci_term_defines.svh"
module pci_term_target #(
	parameter logic [31:0] OPREG_BASE = 32'h00001000,
	parameter logic [31:0] OPREG_MASK = 32'hFFFFFFC0,
	parameter logic [31:0] ROM_BASE = 32'h000C0000,
	parameter logic [31:0] ROM_MASK = 32'hFFFFF800,
	parameter logic [31:0] PASS_BASE = 32'h00010000,
	parameter logic [31:0] PASS_MASK = 32'hFFFF0000
) (
	input wire logic CLK_SYS_I,
	input wire logic RST_B_I,
	pci_term_if.target LINK,
	input wire logic IDSEL_I,
	input wire logic [7:0] SPECIAL_MODES_I,
	input wire logic [31:0] RD_DATA_I,
	input wire logic RD_VALID_I,
	input wire logic RD_PEND_I,
	input wire logic WR_FULL_I,
	input wire logic ROM_READY_I,
	output logic [31:0] ADDR_O,
	output pci_term_pkg::region_type REGION_O,
	output logic XFER_O,
	output logic XFER_WR_O,
	output logic [31:0] XFER_ADDR_O,
	output logic [31:0] WR_DATA_O,
	output logic [3:0] WR_BE_O,
	output logic LOCKED_O
);
	pci_term_pkg::tgt_state_type state_reg, state_next;
	pci_term_pkg::region_type region_reg, hit_region;
	logic devsel_n_reg, devsel_n_next, trdy_n_reg, trdy_n_next, stop_n_reg, stop_n_next;
	logic ad_oe_reg, frame_d_reg, rd_reg, single_reg, first_reg, foreign_reg;
	logic lock_free_reg, claim_d_reg, locked_reg;
	logic [4:0] lat_cnt_reg;
	logic [31:0] addr_reg, ad_tgt_reg;

	// address-phase decode
	wire logic [3:0] cmd = ~LINK.cbe_n;
	wire logic [31:0] ad = LINK.ad;
	wire logic addr_phase = (state_reg == pci_term_pkg::T_IDLE) & ~LINK.frame_n & frame_d_reg;
	wire logic is_rd = (cmd == `CMD_IO_RD) | (cmd == `CMD_MEM_RD) | (cmd == `CMD_CFG_RD)
		| (cmd == `CMD_MEM_RDM) | (cmd == `CMD_MEM_RDL);
	wire logic is_wr = (cmd == `CMD_IO_WR) | (cmd == `CMD_MEM_WR) | (cmd == `CMD_CFG_WR)
		| (cmd == `CMD_MEM_WRI);
	wire logic is_cfg = (cmd == `CMD_CFG_RD) | (cmd == `CMD_CFG_WR);
	wire logic is_io = (cmd == `CMD_IO_RD) | (cmd == `CMD_IO_WR);
	wire logic is_mem = (is_rd | is_wr) & ~is_cfg & ~is_io;
	wire logic hit_cfg = is_cfg & IDSEL_I & (ad[1:0] == `CFG_TYPE0);
	wire logic hit_op = ~is_cfg & ((ad & OPREG_MASK) == OPREG_BASE);
	wire logic hit_rom = is_mem & ((ad & ROM_MASK) == ROM_BASE);
	wire logic hit_pass = ~is_cfg & ((ad & PASS_MASK) == PASS_BASE);
	wire logic claim = addr_phase & (is_rd | is_wr) & (hit_cfg | hit_op | hit_rom | hit_pass);
	assign hit_region = hit_cfg ? pci_term_pkg::RG_CFG : hit_op ? pci_term_pkg::RG_OPREG
		: hit_rom ? pci_term_pkg::RG_ROM : pci_term_pkg::RG_PASS;
	// only the pass-through window with linear order may burst
	wire logic linear = ~is_mem | (ad[1:0] == `BURST_LINEAR);
	wire logic single_hit = (hit_region != pci_term_pkg::RG_PASS) | ~linear;

	// per-phase readiness and refusal
	wire logic pass = (region_reg == pci_term_pkg::RG_PASS);
	wire logic rom = (region_reg == pci_term_pkg::RG_ROM);
	wire logic lat_en = SPECIAL_MODES_I[`LAT_EN_BIT];
	wire logic [4:0] lat_lim = first_reg ? `LAT_FIRST_CLKS : `LAT_LATER_CLKS;
	wire logic lat_over = lat_en & (lat_cnt_reg >= lat_lim);
	wire logic ready = rd_reg ? (pass ? RD_VALID_I : (~rom | ROM_READY_I)) : ~(pass & WR_FULL_I);
	wire logic refuse = foreign_reg
		| (single_reg & ~first_reg)
		| (pass & rd_reg & ~RD_VALID_I & ~RD_PEND_I)
		| (pass & ~rd_reg & WR_FULL_I)
		| (rom & rd_reg & ~ROM_READY_I)
		| (~ready & lat_over);
	wire logic in_data = (state_reg == pci_term_pkg::T_DATA);
	wire logic offer = (state_reg == pci_term_pkg::T_TURN) | (in_data & trdy_n_reg);
	wire logic xfer = in_data & ~trdy_n_reg & ~LINK.irdy_n;
	wire logic burst_try = ~LINK.frame_n & ~LINK.irdy_n;
	// a register read stops only on a real burst; a held frame with idle irdy is a wait
	wire logic stop_with = single_reg & (rd_reg ? burst_try : ~LINK.frame_n);
	wire logic final_xfer = xfer & (LINK.frame_n | ~stop_n_reg);
	wire logic lock_take = claim_d_reg & lock_free_reg & ~LINK.lock_n & ~foreign_reg;
	wire logic lock_drop = final_xfer & LINK.lock_n;
	wire logic ad_oe_next = rd_reg & (state_reg != pci_term_pkg::T_IDLE)
		& (state_next != pci_term_pkg::T_IDLE);

	// termination engine: stop is never driven without device select, so no target abort
	always_comb begin
		state_next = state_reg;
		devsel_n_next = devsel_n_reg;
		trdy_n_next = trdy_n_reg;
		stop_n_next = stop_n_reg;
		case (state_reg)
			pci_term_pkg::T_IDLE: if (claim) begin
				devsel_n_next = 1'b0;
				state_next = is_rd ? pci_term_pkg::T_TURN : pci_term_pkg::T_DATA;
			end
			pci_term_pkg::T_TURN, pci_term_pkg::T_DATA: begin
				if (offer & refuse) begin
					stop_n_next = 1'b0;
					state_next = pci_term_pkg::T_BACKOFF;
				end else if (offer & ready) begin
					trdy_n_next = 1'b0;
					stop_n_next = ~stop_with;
					state_next = pci_term_pkg::T_DATA;
				end else if (offer) begin
					state_next = pci_term_pkg::T_DATA;
				end else if (xfer & LINK.frame_n) begin
					devsel_n_next = 1'b1;
					trdy_n_next = 1'b1;
					stop_n_next = 1'b1;
					state_next = pci_term_pkg::T_IDLE;
				end else if (xfer & ~stop_n_reg) begin
					trdy_n_next = 1'b1;
					state_next = pci_term_pkg::T_BACKOFF;
				end else if (xfer) begin
					trdy_n_next = 1'b1;
					state_next = pci_term_pkg::T_GAP;
				end
			end
			pci_term_pkg::T_GAP: state_next = pci_term_pkg::T_DATA;
			pci_term_pkg::T_BACKOFF: if (LINK.frame_n) begin
				devsel_n_next = 1'b1;
				stop_n_next = 1'b1;
				state_next = pci_term_pkg::T_IDLE;
			end
			default: state_next = pci_term_pkg::T_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			state_reg <= pci_term_pkg::T_IDLE;
			devsel_n_reg <= 1'b1;
			trdy_n_reg <= 1'b1;
			stop_n_reg <= 1'b1;
			ad_oe_reg <= 1'b0;
			frame_d_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			devsel_n_reg <= devsel_n_next;
			trdy_n_reg <= trdy_n_next;
			stop_n_reg <= stop_n_next;
			ad_oe_reg <= ad_oe_next;
			frame_d_reg <= LINK.frame_n;
		end
	end

	// transaction context latched at the address phase
	always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			rd_reg <= 1'b0;
			region_reg <= pci_term_pkg::RG_CFG;
			single_reg <= 1'b0;
			foreign_reg <= 1'b0;
			lock_free_reg <= 1'b0;
			claim_d_reg <= 1'b0;
		end else begin
			claim_d_reg <= claim;
			if (claim) begin
				rd_reg <= is_rd;
				region_reg <= hit_region;
				single_reg <= single_hit;
				foreign_reg <= locked_reg & ~LINK.lock_n;
				lock_free_reg <= LINK.lock_n;
			end
		end
	end

	// latency counter restarts at frame and after each transfer; saturates, never wraps
	always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			lat_cnt_reg <= 5'h00;
			first_reg <= 1'b0;
		end else if (claim) begin
			lat_cnt_reg <= 5'h01;
			first_reg <= 1'b1;
		end else if (xfer) begin
			lat_cnt_reg <= 5'h00;
			first_reg <= 1'b0;
		end else if (lat_cnt_reg != `LAT_CNT_MAX) begin
			lat_cnt_reg <= lat_cnt_reg + 5'h01;
		end
	end

	// lock state; drop wins only at a final transfer with lock released
	always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
		if (!RST_B_I)
			locked_reg <= 1'b0;
		else if (locked_reg & lock_drop & ~foreign_reg)
			locked_reg <= 1'b0;
		else if (lock_take)
			locked_reg <= 1'b1;
	end

	// user-side data path and transfer reports
	always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			addr_reg <= 32'h00000000;
			ad_tgt_reg <= 32'h00000000;
			XFER_O <= 1'b0;
			XFER_WR_O <= 1'b0;
			XFER_ADDR_O <= 32'h00000000;
			WR_DATA_O <= 32'h00000000;
			WR_BE_O <= 4'h0;
		end else begin
			XFER_O <= xfer;
			if (claim)
				addr_reg <= ad;
			else if (xfer)
				addr_reg <= addr_reg + `ADDR_STEP;
			if (offer & ready & rd_reg)
				ad_tgt_reg <= RD_DATA_I;
			if (xfer) begin
				XFER_WR_O <= ~rd_reg;
				XFER_ADDR_O <= addr_reg;
				WR_DATA_O <= ad;
				WR_BE_O <= ~LINK.cbe_n;
			end
		end
	end

	assign LINK.devsel_n = devsel_n_reg;
	assign LINK.trdy_n = trdy_n_reg;
	assign LINK.stop_n = stop_n_reg;
	assign LINK.ad_tgt = ad_tgt_reg;
	assign LINK.ad_tgt_oe = ad_oe_reg;
	assign ADDR_O = addr_reg;
	assign REGION_O = region_reg;
	assign LOCKED_O = locked_reg;
endmodule : pci_term_target
`default_nettype wire
